// ---- hdl/ais_chan_stage.sv ----
`default_nettype none
module ais_chan_stage (
    input wire logic clk,
    input wire logic rst_n,
    input wire ais_pkg::ais_sample_s sampleIn,
    input wire logic [ais_pkg::EXP_W-1:0] exponent,
    input wire logic [ais_pkg::SAMPLE_W-1:0] hyst,
    output logic outValid,
    output logic [ais_pkg::SAMPLE_W-1:0] outCode
);
    import ais_pkg::*;

    ais_prime_e filtState_q, filtState_d;
    ais_prime_e hystState_q, hystState_d;
    logic [ACC_W-1:0] acc_q, acc_d;
    logic filtValid_q, filtValid_d;
    logic [SAMPLE_W-1:0] filtCode_q, filtCode_d;
    logic [SAMPLE_W-1:0] ref_q, ref_d;
    logic outValid_q, outValid_d;
    logic [SAMPLE_W-1:0] outCode_q, outCode_d;
    logic signed [ACC_W:0] diff, step, sum;
    logic signed [SAMPLE_W:0] delta;
    logic [SAMPLE_W:0] mag;

    always_comb begin
        acc_d = acc_q;
        filtState_d = filtState_q;
        filtValid_d = 1'b0;
        filtCode_d = filtCode_q;
        diff = $signed({1'b0, sampleIn.code, {FRAC_W{1'b0}}})
            - $signed({1'b0, acc_q});
        // y += (x - y) / 2^k, same as ((N-1)y + x)/N
        step = diff >>> exponent;
        sum = $signed({1'b0, acc_q}) + step;
        if (sampleIn.valid) begin
            filtValid_d = 1'b1;
            filtState_d = AIS_RUNNING;
            case (filtState_q)
                AIS_UNPRIMED:
                    acc_d = {sampleIn.code, {FRAC_W{1'b0}}};
                default: acc_d = sum[ACC_W-1:0];
            endcase
            filtCode_d = acc_d[ACC_W-1:FRAC_W];
        end
    end

    always_comb begin
        ref_d = ref_q;
        hystState_d = hystState_q;
        outValid_d = 1'b0;
        outCode_d = outCode_q;
        delta = $signed({1'b0, filtCode_q}) - $signed({1'b0, ref_q});
        mag = delta[SAMPLE_W] ? (SAMPLE_W+1)'(0) - delta : delta;
        // filter result feeds the window, never the other way
        if (filtValid_q) begin
            case (hystState_q)
                AIS_UNPRIMED: begin
                    ref_d = filtCode_q;
                    outValid_d = 1'b1;
                    outCode_d = filtCode_q;
                    hystState_d = AIS_RUNNING;
                end
                default: begin
                    // inside +/- hyst: dropped silently
                    if (mag > {1'b0, hyst}) begin
                        ref_d = filtCode_q;
                        outValid_d = 1'b1;
                        outCode_d = filtCode_q;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_q <= '0;
            filtState_q <= AIS_UNPRIMED;
            filtValid_q <= 1'b0;
            filtCode_q <= '0;
            ref_q <= '0;
            hystState_q <= AIS_UNPRIMED;
            outValid_q <= 1'b0;
            outCode_q <= '0;
        end else begin
            acc_q <= acc_d;
            filtState_q <= filtState_d;
            filtValid_q <= filtValid_d;
            filtCode_q <= filtCode_d;
            ref_q <= ref_d;
            hystState_q <= hystState_d;
            outValid_q <= outValid_d;
            outCode_q <= outCode_d;
        end
    end

    assign outValid = outValid_q;
    assign outCode = outCode_q;
endmodule
`default_nettype wire

// ---- hdl/ais_pkg.sv ----
`default_nettype none
package ais_pkg;
    localparam int unsigned SAMPLE_W = 12;
    localparam int unsigned FRAC_W = 16;
    localparam int unsigned ACC_W = SAMPLE_W + FRAC_W;
    localparam int unsigned EXP_W = 5;
    localparam int unsigned CHAN_W = 2;
    localparam int unsigned PIN_W = 8;
    localparam int unsigned NUM_AIN = 4;
    // analog outputs own pins 0..3, inputs follow
    localparam int unsigned AOUT_COUNT = 4;
    localparam logic [EXP_W-1:0] EXP_MAX = 5'h10;
    localparam logic [EXP_W-1:0] EXP_RESET = 5'h03;
    // 10 V full scale over 12 bits: one code is about 2.44 mV
    localparam logic [SAMPLE_W-1:0] HYST_MAX = 12'hfff;
    // 0.01 V is 4.096 codes
    localparam logic [SAMPLE_W-1:0] HYST_RESET = 12'h004;

    typedef struct packed {
        logic valid;
        logic [SAMPLE_W-1:0] code;
    } ais_sample_s;

    typedef struct packed {
        logic valid;
        logic [CHAN_W-1:0] chan;
        logic [EXP_W-1:0] exponent;
        logic [SAMPLE_W-1:0] hyst;
    } ais_cfg_s;

    typedef struct packed {
        logic valid;
        logic [PIN_W-1:0] pin;
        logic [SAMPLE_W-1:0] code;
    } ais_out_s;

    typedef enum logic {
        AIS_UNPRIMED,
        AIS_RUNNING
    } ais_prime_e;
endpackage
`default_nettype wire

// ---- hdl/ais_smoother.sv ----
// How it works
// - each analog input has its own filter and hysteresis, nothing shared.
// - samples go through the lowpass first, then through hysteresis.
// - output becomes ((N-1)*previous + sample)/N with N = 2^exponent.
// - exponent accepted from 0 to 16, reset value 3.
// - filtered values within +/- hysteresis of reference are dropped.
// - values outside the window become output and new reference.
// - hysteresis 0 up to 10 V code, reset to 0.01 V code.
// - outputs are pins 0-3, inputs 4-7, plus offset of earlier modules.
`default_nettype none
module ais_smoother #(
    parameter int unsigned NUM_CH = ais_pkg::NUM_AIN,
    parameter logic [ais_pkg::PIN_W-1:0] PIN_OFFSET = 8'h00
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire ais_pkg::ais_sample_s sampleIn [NUM_CH],
    input wire ais_pkg::ais_cfg_s cfgIn,
    output ais_pkg::ais_out_s result [NUM_CH],
    output logic [ais_pkg::EXP_W-1:0] expNow [NUM_CH],
    output logic [ais_pkg::SAMPLE_W-1:0] hystNow [NUM_CH],
    output logic cfgReject
);
    import ais_pkg::*;

    logic [EXP_W-1:0] exp_q [NUM_CH];
    logic [EXP_W-1:0] exp_d [NUM_CH];
    logic [SAMPLE_W-1:0] hyst_q [NUM_CH];
    logic [SAMPLE_W-1:0] hyst_d [NUM_CH];
    logic cfgReject_q, cfgReject_d;
    ais_out_s result_q [NUM_CH];
    ais_out_s result_d [NUM_CH];
    logic stageValid [NUM_CH];
    logic [SAMPLE_W-1:0] stageCode [NUM_CH];
    logic cfgBad;

    // a bad write changes nothing at all, so a channel never runs
    // with half of a new setting
    always_comb begin
        cfgBad = cfgIn.valid && ((cfgIn.exponent > EXP_MAX)
            || (cfgIn.hyst > HYST_MAX)
            || ({{(32-CHAN_W){1'b0}}, cfgIn.chan} >= NUM_CH));
        cfgReject_d = cfgBad;
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            localparam logic [PIN_W-1:0] PIN_ID =
                PIN_W'(AOUT_COUNT + ch);

            always_comb begin
                exp_d[ch] = exp_q[ch];
                hyst_d[ch] = hyst_q[ch];
                if (cfgIn.valid && !cfgBad
                        && cfgIn.chan == CHAN_W'(ch)) begin
                    exp_d[ch] = cfgIn.exponent;
                    hyst_d[ch] = cfgIn.hyst;
                end
            end

            always_comb begin
                result_d[ch].valid = stageValid[ch];
                result_d[ch].code = stageValid[ch] ? stageCode[ch]
                    : result_q[ch].code;
                result_d[ch].pin = PIN_OFFSET + PIN_ID;
            end

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    exp_q[ch] <= EXP_RESET;
                    hyst_q[ch] <= HYST_RESET;
                    result_q[ch] <= '0;
                end else begin
                    exp_q[ch] <= exp_d[ch];
                    hyst_q[ch] <= hyst_d[ch];
                    result_q[ch] <= result_d[ch];
                end
            end

            // one private stage per channel
            ais_chan_stage u_stage (
                .clk(clk),
                .rst_n(rst_n),
                .sampleIn(sampleIn[ch]),
                .exponent(exp_q[ch]),
                .hyst(hyst_q[ch]),
                .outValid(stageValid[ch]),
                .outCode(stageCode[ch])
            );

            assign result[ch] = result_q[ch];
            assign expNow[ch] = exp_q[ch];
            assign hystNow[ch] = hyst_q[ch];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfgReject_q <= 1'b0;
        end else begin
            cfgReject_q <= cfgReject_d;
        end
    end

    assign cfgReject = cfgReject_q;
endmodule
`default_nettype wire

// ---- verification/ais_smoother_properties.sv ----
`default_nettype none
module ais_smoother_properties
    import ais_pkg::*;
#(parameter int unsigned NUM_CH = 4,
  parameter logic [7:0] PIN_OFFSET = 8'h00) (
    input wire logic clk,
    input wire logic rst_n,
    input wire ais_pkg::ais_sample_s sampleIn [NUM_CH],
    input wire ais_pkg::ais_cfg_s cfgIn,
    input wire ais_pkg::ais_out_s result [NUM_CH],
    input wire logic [4:0] expNow [NUM_CH],
    input wire logic [11:0] hystNow [NUM_CH],
    input wire logic cfgReject
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rst; $past(!rst_n) |-> expNow[0] == EXP_RESET; endproperty
    a_rst: assert property (p_rst) else $error("exp reset");
    property p_rsth; $past(!rst_n) |-> hystNow[3] == HYST_RESET; endproperty
    a_rsth: assert property (p_rsth) else $error("hyst reset");
    property p_lat;
        result[0].valid |-> $past(sampleIn[0].valid, 3); endproperty
    a_lat: assert property (p_lat) else $error("latency");
    // reset edges move the code without a pulse; skip them
    property p_hold;
        $past(rst_n) && $changed(result[0].code) |-> result[0].valid;
    endproperty
    a_hold: assert property (p_hold) else $error("code moved");
    property p_pin; $past(rst_n) |-> result[1].pin == PIN_OFFSET + 8'h05;
    endproperty
    a_pin: assert property (p_pin) else $error("pin");
    property p_cfg;
        cfgIn.valid && cfgIn.chan == 2'h0 && cfgIn.exponent <= EXP_MAX |=>
            expNow[0] == $past(cfgIn.exponent)
            && hystNow[0] == $past(cfgIn.hyst);
    endproperty
    a_cfg: assert property (p_cfg) else $error("cfg");
    property p_rej; cfgIn.valid && cfgIn.exponent > EXP_MAX |=>
        cfgReject && $stable(expNow[2]); endproperty
    a_rej: assert property (p_rej) else $error("not refused");
    property p_why;
        cfgReject |-> $past(cfgIn.valid && cfgIn.exponent > EXP_MAX);
    endproperty
    a_why: assert property (p_why) else $error("refused");
    property p_own; cfgIn.valid && cfgIn.chan != 2'h0 |=> $stable(expNow[0]);
    endproperty
    a_own: assert property (p_own) else $error("shared");
    c_acc: cover property (result[0].valid);
    c_rej: cover property (cfgReject);
    c_max: cover property (cfgIn.valid && cfgIn.exponent == EXP_MAX);
endmodule
bind ais_smoother ais_smoother_properties #(.NUM_CH(NUM_CH),
    .PIN_OFFSET(PIN_OFFSET)) u_props (.clk(clk), .rst_n(rst_n),
    .sampleIn(sampleIn), .cfgIn(cfgIn), .result(result), .expNow(expNow),
    .hystNow(hystNow), .cfgReject(cfgReject));
`default_nettype wire

// ---- verification/ais_adc_model.sv ----
`default_nettype none
module ais_adc_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [1:0] chan,
    input wire logic [11:0] code,
    output ais_pkg::ais_sample_s sampleOut [4]
);
    timeunit 1ns;
    timeprecision 1ns;
    import ais_pkg::*;
    initial sampleOut = '{default: '0};
    // idle channels flip their code so a stale value never looks valid
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            sampleOut[i].valid <= go && chan == 2'(i);
            sampleOut[i].code <= (go && chan == 2'(i)) ? code
                : ~sampleOut[i].code;
        end
    end
endmodule
`default_nettype wire

// ---- verification/ais_smoother_test.sv ----
`default_nettype none
module ais_smoother_test;
    timeunit 1ns;
    timeprecision 1ns;
    import ais_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, cfgReject;
    logic [1:0] chan = 2'h0;
    logic [11:0] code = 12'h000, hystNow [4], refE [4];
    logic [11:0] hE [4] = '{default: HYST_RESET};
    logic [4:0] expNow [4], kE [4] = '{default: EXP_RESET};
    logic [27:0] accE [4];
    bit primed [4] = '{default: 1'b0};
    ais_cfg_s cfgIn = '0;
    ais_sample_s sampleIn [4];
    ais_out_s result [4];
    int err_count = 0, checks = 0;
    // edges from the end of a request to the result pulse
    localparam int LAT_EDGES = 3;
    initial forever #5 clk = ~clk;
    ais_adc_model u_adc (.clk(clk), .go(go), .chan(chan), .code(code),
        .sampleOut(sampleIn));
    ais_smoother #(.PIN_OFFSET(8'h10)) u_dut (.clk(clk), .rst_n(rst_n),
        .sampleIn(sampleIn), .cfgIn(cfgIn), .result(result),
        .expNow(expNow), .hystNow(hystNow), .cfgReject(cfgReject));
    task automatic cmp(string what, logic [11:0] e, logic [11:0] s);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic cfg(logic [1:0] ch, logic [4:0] k, logic [11:0] h);
        logic bad;
        bad = k > EXP_MAX;
        @(posedge clk);
        cfgIn <= '{1'b1, ch, k, h};
        @(posedge clk);
        cfgIn.valid <= 1'b0;
        #1;
        if (!bad) begin
            kE[ch] = k;
            hE[ch] = h;
        end
        cmp("reject", 12'(bad), 12'(cfgReject));
        cmp("exp", 12'(kE[ch]), 12'(expNow[ch]));
        cmp("hyst", hE[ch], hystNow[ch]);
    endtask
    task automatic send(logic [1:0] ch, logic [11:0] x);
        logic signed [28:0] diff;
        logic [11:0] f;
        logic take;
        int n;
        // bench keeps its own 12.16 accumulator, truncating like the shift
        diff = $signed({1'b0, x, 16'h0000}) - $signed({1'b0, accE[ch]});
        accE[ch] = primed[ch] ? accE[ch] + 28'(diff >>> kE[ch])
            : {x, 16'h0000};
        f = accE[ch][27:16];
        take = !primed[ch] || (f > refE[ch] ? f - refE[ch]
            : refE[ch] - f) > hE[ch];
        primed[ch] = 1'b1;
        if (take)
            refE[ch] = f;
        @(posedge clk);
        go <= 1'b1;
        chan <= ch;
        code <= x;
        @(posedge clk);
        go <= 1'b0;
        for (n = 0; n < 8 && result[ch].valid !== 1'b1; n++)
            @(posedge clk) #1;
        cmp("accepted", 12'(take), 12'(result[ch].valid));
        cmp("code", refE[ch], result[ch].code);
        if (take)
            cmp("latency", 12'(LAT_EDGES), 12'(n));
        // an accepted value that never shows ends the run here
        if (take && n == 8)
            tally_and_finish;
    endtask
    task automatic t_reset;
        #1;
        for (int i = 0; i < 4; i++) begin
            cmp("exp0", 12'(EXP_RESET), 12'(expNow[i]));
            cmp("hyst0", HYST_RESET, hystNow[i]);
            cmp("pin", 12'(8'h14 + i), 12'(result[i].pin));
        end
    endtask
    task automatic t_filter;
        send(2'h0, 12'h3e8);
        send(2'h0, 12'h7d0);
        cfg(2'h0, 5'h02, 12'h004);
        send(2'h0, 12'h7d0);
        send(2'h0, 12'h000);
    endtask
    task automatic t_window;
        cfg(2'h1, 5'h00, 12'h00a);
        send(2'h1, 12'h1f4);
        send(2'h1, 12'h1fe);
        send(2'h1, 12'h1ff);
        send(2'h1, 12'h1f5);
    endtask
    task automatic t_limits;
        cfg(2'h2, 5'h11, 12'h000);
        cfg(2'h2, EXP_MAX, HYST_MAX);
        send(2'h2, 12'h800);
        send(2'h2, 12'h000);
    endtask
    task automatic t_rereset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        kE = '{default: EXP_RESET};
        hE = '{default: HYST_RESET};
        primed = '{default: 1'b0};
        t_reset;
        // close to the old reference: only a fresh start accepts it
        send(2'h1, 12'h1fd);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset;
        t_filter;
        t_window;
        t_limits;
        t_rereset;
        tally_and_finish;
    end
endmodule
`default_nettype wire
